// *** pkg/anrb_regs.svh ***
// register offsets, field positions and reset values of the node register bank
`ifndef ANRB_REGS_SVH
`define ANRB_REGS_SVH
`define ANRB_WIN_START32 32'he1800000
`define ANRB_WIN_START30 32'h21800000
`define ANRB_WIN_SIZE 32'h00080000
`define ANRB_OFF_IDENT 20'h00000
`define ANRB_OFF_BERR 20'h00004
`define ANRB_OFF_FADR 20'h00008
`define ANRB_OFF_REAR 20'h0000c
`define ANRB_OFF_ESUM 20'h00010
`define ANRB_OFF_IMASK 20'h00014
`define ANRB_OFF_IVDEST 20'h00018
`define ANRB_OFF_DIAG1 20'h0001c
`define ANRB_OFF_UTIL 20'h00020
`define ANRB_OFF_CSR 20'h00024
`define ANRB_OFF_RVEC 20'h00028
`define ANRB_OFF_FAER 20'h0002c
`define ANRB_OFF_BEAR 20'h00030
`define ANRB_OFF_PMAP_FIRST 20'h00020
`define ANRB_OFF_PMAP_LAST 20'h401fc
`define ANRB_PMAP_WORDS 16
`define ANRB_RST_ESUM 32'h80000020
`define ANRB_RST_UTIL 32'h43f00000
`define ANRB_RST_CSR 32'h00000180
`define ANRB_RST_ZERO 32'h00000000
`define ANRB_BIT_ES 31
`define ANRB_BIT_NODE_RESET_TRIGGER 30
`define ANRB_BIT_DXTO 2
`define ANRB_BIT_STF 10
`define ANRB_FCID_LO 4
`define ANRB_FCID_HI 9
`define ANRB_BERR_W1C 32'h09ffb400
`define ANRB_BERR_SUM 32'h09ffb400
`define ANRB_NODE_RESET_TRIGGER_PULSE 4'h8
`endif

// *** pkg/anrb_pkg.sv ***
// types shared by the node register bank
package anrb_pkg;
    // one host access request
    typedef struct packed {
        logic rd;
        logic wr;
        logic [31:0] addr;
        logic [31:0] wdata;
    } anrb_req_t;
    // error event report from the adapter core
    typedef struct packed {
        logic [31:0] setBits;
        logic [5:0] commander;
    } anrb_err_t;
    // node reset sequencer states
    typedef enum logic [1:0] {
        RST_IDLE = 2'b01,
        RST_BUSY = 2'b10
    } anrb_rst_t;
endpackage

// *** logic/anrb_register_bank.sv ***
// host-side register bank of the bus adapter node
`timescale 1ns/1ps
`include "anrb_regs.svh"

// What this block does
// R1 - base equals window start plus id times size
// R2 - write one clears, zero leaves bit
// R3 - write one sets, self clears later
// R4 - read-zero set bits still act, self clear
// R5 - power-up values per bit marking
// R6 - thirteen word registers from offset zero
// R7 - page map array ends at upper offset
// R8 - summary, utility, control reset nonzero values
// R9 - other logging registers reset to zero
// R10 - mask and destination bits software initialised
// R11 - identification loaded, zero means uninitialised
// R12 - upper identification half is revision
// R13 - lower identification half is type code
// R14 - error log locked until bits cleared
// R15 - top error bit ORs error bits
// R16 - summary covers listed bits, not control
// R17 - log failing commander identifier
// R18 - node reset bit resets all but mask and destination, reads zero
// R19 - host uses aligned longword accesses only
module anrb_register_bank #(
    parameter logic [15:0] MODULE_REVISION = 16'h0001,
    // arbitrary neutral type code
    parameter logic [15:0] NODE_TYPE = 16'h0a5a
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // node strapping
    input wire logic [3:0] nodeId,
    input wire logic wide30,
    // host access port
    input wire anrb_pkg::anrb_req_t hostReq,
    output logic [31:0] readData,
    output logic readValid,
    output logic hit,
    // adapter core events
    input wire anrb_pkg::anrb_err_t errIn,
    input wire logic [31:0] failAddrIn,
    // controls to the adapter core
    output logic timeoutDisable,
    output logic nodeReset,
    output logic vmeSysReset
);
    // one host request per cycle, answered in the next cycle
    // all storage is flip-flops; no wait states are inserted
    // node reset sequencer
    // state register, one-hot idle or busy
    anrb_pkg::anrb_rst_t rstState;
    // cycles left in the node reset pulse
    logic [3:0] rstCount;
    // register storage
    // bus error flags, commander id, timeout disable
    logic [31:0] berr;
    // failing address, frozen while locked
    logic [31:0] fadr;
    // responder error address
    logic [31:0] rear;
    // error summary
    logic [31:0] esum;
    // interrupt mask, kept across node reset
    logic [31:0] imask;
    // implied vector destination, kept across node reset
    logic [31:0] ivdest;
    // first diagnostic register
    logic [31:0] diag1;
    // utility settings
    logic [31:0] util;
    // control and status
    logic [31:0] csr;
    // return vector
    logic [31:0] rvec;
    // failing address extension, no capture source yet
    logic [31:0] faer;
    // remote bus error address
    logic [31:0] bear;
    // page map words, flip-flops indexed by word
    logic [31:0] pmap [`ANRB_PMAP_WORDS];
    // decode helpers
    // node window base address
    logic [31:0] base;
    // request address relative to base
    logic [31:0] offs;
    // request falls inside this node's window
    logic inWin;
    // longword aligned request
    logic aligned;
    // accepted write and read strobes
    logic wrOk;
    logic rdOk;
    // low offset bits used by the decoders
    logic [19:0] off;
    // any summary error bit stands
    logic locked;
    // read mux result and decode hit
    logic [31:0] next_data;
    logic next_hit;

    // R1 node window base from id and mode
    // the product stays inside 32 bits for all sixteen ids
    assign base = (wide30 ? `ANRB_WIN_START30 : `ANRB_WIN_START32)
        + (`ANRB_WIN_SIZE * {28'h0000000, nodeId});
    // wraps below base, so one compare covers both ends
    assign offs = hostReq.addr - base;
    assign inWin = (offs < `ANRB_WIN_SIZE);
    // R19 misaligned accesses ignored
    // byte and word accesses are dropped, not merged
    assign aligned = (hostReq.addr[1:0] == 2'h0);
    // window is 19 bits wide, twenty offset bits suffice
    assign off = offs[19:0];
    // outside or misaligned accesses change nothing
    assign wrOk = hostReq.wr & inWin & aligned;
    assign rdOk = hostReq.rd & inWin & aligned;
    // R14 log frozen while any error bit stands
    assign locked = |(berr & `ANRB_BERR_SUM);

    // node reset sequencer, holds reset some cycles
    // a fixed pulse keeps the far bus reset long enough
    // without software having to time it
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            // no node reset pending after pin reset
            rstState <= anrb_pkg::RST_IDLE;
            rstCount <= 4'h0;
            nodeReset <= 1'b0;
            vmeSysReset <= 1'b0;
        end else begin
            case (rstState)
                anrb_pkg::RST_IDLE: begin
                    // R18 write one starts node reset
                    // waits for a write of one to the trigger bit
                    if (wrOk && off == `ANRB_OFF_BERR &&
                        hostReq.wdata[`ANRB_BIT_NODE_RESET_TRIGGER]) begin
                        rstState <= anrb_pkg::RST_BUSY;
                        rstCount <= `ANRB_NODE_RESET_TRIGGER_PULSE;
                        // both resets rise together
                        nodeReset <= 1'b1;
                        vmeSysReset <= 1'b1;
                    end
                end
                anrb_pkg::RST_BUSY: begin
                    // R3 trigger clears itself
                    // count down, release after the last cycle
                    if (rstCount == 4'h1) begin
                        rstState <= anrb_pkg::RST_IDLE;
                        nodeReset <= 1'b0;
                        vmeSysReset <= 1'b0;
                    end
                    rstCount <= rstCount - 4'h1;
                end
                default: begin
                    // illegal code falls back to idle
                    rstState <= anrb_pkg::RST_IDLE;
                end
            endcase
        end
    end

    // bus error register; flags set by core, cleared by host
    // reserved and read-only positions never take host data
    // so a careless write cannot fake an error
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            // R5 self-test flag set at power-up
            berr <= 32'h00000400;
        end else if (nodeReset) begin
            // node reset restores the power-up flags
            berr <= 32'h00000400;
        end else begin
            // R2 write one clears, set wins
            // events in the clear cycle survive the clear
            // bit 2 is plain read/write, taken from every write
            if (wrOk && off == `ANRB_OFF_BERR) begin
                berr <= (berr & ~(hostReq.wdata & `ANRB_BERR_W1C)
                    & ~32'h00000004) | (errIn.setBits & `ANRB_BERR_W1C)
                    | {29'h0, hostReq.wdata[`ANRB_BIT_DXTO], 2'h0};
            end else begin
                // no write, only new events
                berr <= berr | (errIn.setBits & `ANRB_BERR_W1C);
            end
            // R17 commander captured while unlocked
            // first failure keeps its commander until cleared
            if (!locked && |(errIn.setBits & `ANRB_BERR_SUM)) begin
                berr[`ANRB_FCID_HI:`ANRB_FCID_LO] <= errIn.commander;
            end
        end
    end

    // failing address log, frozen while locked
    // captured every cycle until an error locks it
    // extension has no capture source, stays zero
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            fadr <= `ANRB_RST_ZERO;
            faer <= `ANRB_RST_ZERO;
        end else if (nodeReset) begin
            // node reset clears the log
            fadr <= `ANRB_RST_ZERO;
            faer <= `ANRB_RST_ZERO;
        end else if (!locked) begin
            // R14 capture only when unlocked
            fadr <= failAddrIn;
        end
    end

    // R8 R9 R10 host read/write registers with resets
    // mask and destination reset to zero at pin reset only,
    // software must load them before use
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            rear <= `ANRB_RST_ZERO;
            esum <= `ANRB_RST_ESUM;
            imask <= `ANRB_RST_ZERO;
            ivdest <= `ANRB_RST_ZERO;
            diag1 <= `ANRB_RST_ZERO;
            util <= `ANRB_RST_UTIL;
            csr <= `ANRB_RST_CSR;
            rvec <= `ANRB_RST_ZERO;
            bear <= `ANRB_RST_ZERO;
        end else if (nodeReset) begin
            // mask and destination keep their contents
            rear <= `ANRB_RST_ZERO;
            esum <= `ANRB_RST_ESUM;
            diag1 <= `ANRB_RST_ZERO;
            util <= `ANRB_RST_UTIL;
            csr <= `ANRB_RST_CSR;
            rvec <= `ANRB_RST_ZERO;
            bear <= `ANRB_RST_ZERO;
        end else if (wrOk) begin
            // R6 word register decode
            // read-only offsets fall to the default branch
            case (off)
                // responder error address
                `ANRB_OFF_REAR: rear <= hostReq.wdata;
                // error summary
                `ANRB_OFF_ESUM: esum <= hostReq.wdata;
                // interrupt mask
                `ANRB_OFF_IMASK: imask <= hostReq.wdata;
                // implied vector destination
                `ANRB_OFF_IVDEST: ivdest <= hostReq.wdata;
                // first diagnostic
                `ANRB_OFF_DIAG1: diag1 <= hostReq.wdata;
                // utility settings
                `ANRB_OFF_UTIL: util <= hostReq.wdata;
                // control and status
                `ANRB_OFF_CSR: csr <= hostReq.wdata;
                // return vector
                `ANRB_OFF_RVEC: rvec <= hostReq.wdata;
                // remote bus error address
                `ANRB_OFF_BEAR: bear <= hostReq.wdata;
                default: begin
                    // identification and error offsets elsewhere
                end
            endcase
        end
    end

    // R7 page map words, ending at offset 0x401fc inside the window
    // four byte stride, last word at the upper offset
    // only a few words are kept to save flip-flops
    genvar gi;
    generate
        for (gi = 0; gi < `ANRB_PMAP_WORDS; gi++) begin : gPmap
            // each word compares its own fixed offset
            always_ff @(posedge core_clk or posedge rst) begin
                if (rst) begin
                    pmap[gi] <= `ANRB_RST_ZERO;
                end else if (nodeReset) begin
                    // node reset clears the map
                    pmap[gi] <= `ANRB_RST_ZERO;
                end else if (wrOk && off == 20'(`ANRB_OFF_PMAP_LAST
                    - 20'(4 * (`ANRB_PMAP_WORDS - 1 - gi)))) begin
                    pmap[gi] <= hostReq.wdata;
                end
            end
        end
    endgenerate

    // read mux
    // purely combinational, the answer is registered below
    // so the read path costs one cycle of latency
    always_comb begin
        next_data = 32'h00000000;
        next_hit = 1'b1;
        case (off)
            // R11 R12 R13 identification halves
            `ANRB_OFF_IDENT: next_data = {MODULE_REVISION, NODE_TYPE};
            // R4 R15 R16 summary bit, node reset reads zero
            // bit 30 is the trigger, it never reads back
            `ANRB_OFF_BERR: next_data = {|(berr & `ANRB_BERR_SUM),
                1'b0, berr[29:0]};
            `ANRB_OFF_FADR: next_data = fadr;
            `ANRB_OFF_REAR: next_data = rear;
            `ANRB_OFF_ESUM: next_data = esum;
            `ANRB_OFF_IMASK: next_data = imask;
            `ANRB_OFF_IVDEST: next_data = ivdest;
            `ANRB_OFF_DIAG1: next_data = diag1;
            `ANRB_OFF_UTIL: next_data = util;
            `ANRB_OFF_CSR: next_data = csr;
            `ANRB_OFF_RVEC: next_data = rvec;
            `ANRB_OFF_FAER: next_data = faer;
            `ANRB_OFF_BEAR: next_data = bear;
            default: begin
                // unknown offsets give zero and no hit
                next_hit = 1'b0;
                // page map lookup, at most one word matches
                for (int i = 0; i < `ANRB_PMAP_WORDS; i++) begin
                    if (off == 20'(`ANRB_OFF_PMAP_LAST
                        - 20'(4 * (`ANRB_PMAP_WORDS - 1 - i)))) begin
                        next_data = pmap[i];
                        next_hit = 1'b1;
                    end
                end
            end
        endcase
    end

    // registered read answer, one cycle after request
    // every output comes from a flip-flop, so the host
    // never sees decoder glitches
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            // quiet bus after reset
            readData <= 32'h00000000;
            readValid <= 1'b0;
            hit <= 1'b0;
            timeoutDisable <= 1'b0;
        end else begin
            // data only in the cycle after an accepted read
            readData <= rdOk ? next_data : 32'h00000000;
            readValid <= rdOk;
            // hit also covers writes to decoded offsets
            hit <= (rdOk | wrOk) & next_hit;
            // timeout disable mirrors bus error bit 2
            timeoutDisable <= berr[`ANRB_BIT_DXTO];
        end
    end
endmodule

// *** sim/anrb_register_bank_assertions.sv ***
// port checker of the node register bank
`timescale 1ns/1ps
`include "anrb_regs.svh"
module anrb_register_bank_assertions #(
    parameter logic [15:0] MODULE_REVISION = 16'h0001,
    parameter logic [15:0] NODE_TYPE = 16'h0a5a
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // strapping and requests
    input wire logic [3:0] nodeId,
    input wire logic wide30,
    input wire anrb_pkg::anrb_req_t hostReq,
    input wire anrb_pkg::anrb_err_t errIn,
    input wire logic [31:0] failAddrIn,
    // answers and controls
    input wire logic [31:0] readData,
    input wire logic readValid,
    input wire logic hit,
    input wire logic timeoutDisable,
    input wire logic nodeReset,
    input wire logic vmeSysReset
);
    // node base and offset of the current request
    logic [31:0] base;
    logic [31:0] off;
    logic req;
    assign base = (wide30 ? `ANRB_WIN_START30 : `ANRB_WIN_START32)
        + `ANRB_WIN_SIZE * nodeId;
    assign off = hostReq.addr - base;
    assign req = hostReq.rd | hostReq.wr;
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    valid_after_read_a: assert property (
        readValid |-> $past(hostReq.rd)) else $error("stray read valid");
    quiet_read_data_a: assert property (
        !readValid |-> readData == 32'h0) else $error("data without read");
    hit_has_cause_a: assert property (
        hit |-> $past(req)) else $error("hit without request");
    misaligned_refused_a: assert property (
        req && hostReq.addr[1:0] != 2'h0 |=> !hit)
        else $error("misaligned access hit");
    window_refused_a: assert property (
        req && off >= `ANRB_WIN_SIZE |=> !hit)
        else $error("out of window access hit");
    ident_value_a: assert property (
        hostReq.rd && off == 32'h0 && !nodeReset |=> hit
        && readData == {MODULE_REVISION, NODE_TYPE}) else $error("bad ident");
    summary_or_a: assert property (
        hostReq.rd && off == 32'h4 && !nodeReset |=> !readData[30]
        && readData[31] == |(readData & `ANRB_BERR_SUM))
        else $error("bad error summary");
    reset_trigger_a: assert property (
        hostReq.wr && off == 32'h4 && hostReq.wdata[30] && !nodeReset
        |-> ##[1:12] nodeReset) else $error("node reset missing");
    sys_reset_tie_a: assert property (
        nodeReset == vmeSysReset) else $error("bus reset apart");
    cover property (hostReq.rd && off == 32'h0);
    cover property ($rose(nodeReset));
    cover property (errIn.setBits != 32'h0);
endmodule

// *** sim/anrb_host_model.sv ***
// host processor model issuing register accesses
`timescale 1ns/1ps
module anrb_host_model (
    // clock
    input wire logic core_clk,
    // request out, answer back
    output anrb_pkg::anrb_req_t hostReq,
    input wire logic [31:0] readData,
    input wire logic hit
);
    initial hostReq = '0;
    task xfer(input logic w, input logic [31:0] a, input logic [31:0] d,
        output logic [31:0] q, output logic h);
        @(posedge core_clk);
        #1 hostReq = '{~w, w, a, d};
        @(posedge core_clk);
        #1 q = readData;
        h = hit;
        // released lines show the inverse, never stale values
        hostReq = '{1'b0, 1'b0, ~a, ~d};
    endtask
endmodule

// *** sim/testbench.sv ***
// self-checking bench of the node register bank
`timescale 1ns/1ps
`include "anrb_regs.svh"
module testbench;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic [3:0] nodeId = 4'h3;
    logic wide30 = 1'b0;
    anrb_pkg::anrb_req_t hostReq;
    anrb_pkg::anrb_err_t errIn = '0;
    logic [31:0] failAddrIn = 32'h0;
    logic [31:0] readData, q;
    logic readValid, hit, timeoutDisable, nodeReset, vmeSysReset, h;
    int err_count = 0;
    int samples_checked = 0;
    int cyc = 0;
    logic [19:0] zeroOff [6] = '{20'h0000c, 20'h0001c, 20'h00028,
        20'h0002c, 20'h00030, 20'h401c0};
    anrb_register_bank uut (.core_clk(core_clk), .rst(rst), .nodeId(nodeId),
        .wide30(wide30), .hostReq(hostReq), .readData(readData),
        .readValid(readValid), .hit(hit), .errIn(errIn),
        .failAddrIn(failAddrIn), .timeoutDisable(timeoutDisable),
        .nodeReset(nodeReset), .vmeSysReset(vmeSysReset));
    anrb_host_model host (.core_clk(core_clk), .hostReq(hostReq),
        .readData(readData), .hit(hit));
    always #12.5 core_clk = ~core_clk;
    function automatic logic [31:0] base();
        return (wide30 ? `ANRB_WIN_START30 : `ANRB_WIN_START32)
            + `ANRB_WIN_SIZE * nodeId;
    endfunction
    task chk(input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            err_count++;
            $display("FAIL t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask
    task rd(input logic [19:0] o, input logic [31:0] m, input logic [31:0] e);
        host.xfer(1'b0, base() + o, 32'h0, q, h);
        chk(e, q & m);
        chk(32'h1, h);
        chk(32'h1, readValid);
    endtask
    task wr(input logic [19:0] o, input logic [31:0] d);
        host.xfer(1'b1, base() + o, d, q, h);
    endtask
    // one-cycle error event from the core
    task pulse(input logic [5:0] c, input logic [31:0] b);
        @(posedge core_clk);
        #1 errIn = '{b, c};
        @(posedge core_clk);
        #1 errIn = '0;
    endtask
    task t_reset;
        rd(`ANRB_OFF_IDENT, '1, 32'h00010a5a);
        rd(`ANRB_OFF_BERR, '1, 32'h80000400);
        rd(`ANRB_OFF_ESUM, '1, `ANRB_RST_ESUM);
        rd(`ANRB_OFF_UTIL, '1, `ANRB_RST_UTIL);
        rd(`ANRB_OFF_CSR, '1, `ANRB_RST_CSR);
        foreach (zeroOff[i]) rd(zeroOff[i], '1, 32'h0);
        $display("t_reset done");
    endtask
    task t_w1c;
        wr(`ANRB_OFF_BERR, 32'h0);
        rd(`ANRB_OFF_BERR, '1, 32'h80000400);
        wr(`ANRB_OFF_BERR, 32'h400);
        rd(`ANRB_OFF_BERR, '1, 32'h0);
        failAddrIn = 32'h12345678;
        pulse(6'h15, 32'h00800000);
        failAddrIn = 32'hcafe0000;
        pulse(6'h2a, 32'h00050000);
        rd(`ANRB_OFF_BERR, '1, 32'h80850150);
        rd(`ANRB_OFF_FADR, '1, 32'h12345678);
        wr(`ANRB_OFF_BERR, 32'h00850000);
        rd(`ANRB_OFF_BERR, 32'h89ffb400, 32'h0);
        wr(`ANRB_OFF_BERR, 32'h4);
        @(posedge core_clk);
        #1;
        chk(32'h1, timeoutDisable);
        rd(`ANRB_OFF_BERR, 32'h4, 32'h4);
        $display("t_w1c done");
    endtask
    task t_win;
        host.xfer(1'b0, base() + `ANRB_WIN_SIZE, 32'h0, q, h);
        chk(32'h0, h);
        host.xfer(1'b0, base() + 32'h2, 32'h0, q, h);
        chk(32'h0, h);
        host.xfer(1'b0, base() + 32'h100, 32'h0, q, h);
        chk(32'h0, h);
        wr(20'h401fc, 32'h5a5a0001);
        rd(20'h401fc, '1, 32'h5a5a0001);
        wide30 = 1'b1;
        rd(`ANRB_OFF_IDENT, '1, 32'h00010a5a);
        wide30 = 1'b0;
        $display("t_win done");
    endtask
    task t_node_reset_trigger;
        int n;
        wr(`ANRB_OFF_BERR, 32'h40000004);
        for (n = 0; n < 20 && nodeReset !== 1'b1; n++) begin
            @(posedge core_clk);
            #1;
        end
        chk(32'h1, nodeReset);
        chk(32'h1, vmeSysReset);
        for (n = 0; n < 40 && nodeReset !== 1'b0; n++) begin
            @(posedge core_clk);
            #1;
        end
        chk(32'h0, nodeReset);
        chk(32'h0, timeoutDisable);
        rd(`ANRB_OFF_BERR, '1, 32'h80000400);
        $display("t_node_reset_trigger done");
    endtask
    task end_sim;
        $display("checks %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // hang guard well past the expected run
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 3000) begin
            err_count++;
            end_sim();
        end
    end
    initial begin
        repeat (2) @(posedge core_clk);
        #1 rst = 1'b0;
        t_reset();
        t_w1c();
        t_win();
        t_node_reset_trigger();
        end_sim();
    end
endmodule
bind anrb_register_bank anrb_register_bank_assertions #(
    .MODULE_REVISION(MODULE_REVISION), .NODE_TYPE(NODE_TYPE)) chk_i (
    .core_clk(core_clk), .rst(rst), .nodeId(nodeId), .wide30(wide30),
    .hostReq(hostReq), .errIn(errIn), .failAddrIn(failAddrIn),
    .readData(readData), .readValid(readValid), .hit(hit),
    .timeoutDisable(timeoutDisable), .nodeReset(nodeReset),
    .vmeSysReset(vmeSysReset));
